/* File: inc/ccs_pkg.sv */
// Constants, types and register map for the card control steering block.
// Assumes a single 200 MHz clock and a plain strobe register port.
package ccs_pkg;
	localparam int unsigned CLK_MHZ     = 200;
	localparam int unsigned WARM_CYCLES = 42000;
	localparam int unsigned T1_CYCLES   = 1000;

	localparam logic [3:0] ADR_CTRL   = 4'h0;
	localparam logic [3:0] ADR_STATUS = 4'h4;
	localparam logic [3:0] ADR_IRQ_EN = 4'h8;
	localparam logic [3:0] ADR_IRQ_CLR = 4'hc;

	localparam int unsigned CTRL_START = 0;
	localparam int unsigned CTRL_WARM  = 1;
	localparam int unsigned CTRL_IO_EN = 7;

	localparam int unsigned ST_PRESENT = 0;
	localparam int unsigned ST_EARLY   = 1;
	localparam int unsigned ST_MUTE    = 2;
	localparam int unsigned ST_CHANGE  = 3;
	localparam int unsigned ST_OVT     = 4;
	localparam int unsigned ST_OVC     = 5;
	localparam int unsigned ST_VCC     = 6;
	localparam int unsigned ST_VDD     = 7;

	localparam logic [7:0] CTRL_RST   = 8'h00;
	localparam logic [7:0] IRQ_EN_RST = 8'hfe;

	localparam int unsigned LINE_DATA  = 0;
	localparam int unsigned LINE_AUX_A = 1;
	localparam int unsigned LINE_AUX_B = 2;
	localparam int unsigned NUM_LINES  = 3;

	localparam int unsigned EVT_W = 8;
	localparam logic [13:0] SYNC_RST = 14'h3f00;

	typedef struct packed {
		logic vdd_fault;
		logic vcc_fault;
		logic over_current;
		logic over_temp;
		logic atr_start;
		logic mute;
		logic early_atr;
		logic present;
	} ccs_evt_t;

	typedef struct packed {
		logic [NUM_LINES-1:0] out;
		logic [NUM_LINES-1:0] oe;
	} ccs_od_t;

	typedef enum logic [1:0] {
		DIR_IDLE,
		DIR_HOST_IN,
		DIR_CARD_IN
	} ccs_dir_t;
endpackage : ccs_pkg

/* File: verilog/ccs_sync.sv */
// Three-stage input synchroniser with agreement filter.
// Assumes asynchronous pin inputs; output changes when stages two and three agree.
`timescale 1ns/1ps
module ccs_sync
	import ccs_pkg::*;
#(
	parameter int unsigned W   = 14,
	parameter logic [W-1:0] RST = '0
)(
	// Clock and reset
	input  wire logic         ref_clk,
	input  wire logic         arst_n,
	// Data
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] s1_q, s2_q, s3_q, q_d;

	always_comb
	begin
		for (int i = 0; i < W; i++)
		begin
			q_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : q[i];
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			s1_q <= RST;
			s2_q <= RST;
			s3_q <= RST;
			q    <= RST;
		end
		else
		begin
			s1_q <= d;
			s2_q <= s1_q;
			s3_q <= s2_q;
			q    <= q_d;
		end
	end
endmodule : ccs_sync

/* File: verilog/ccs_top.sv */
// Interrupt, warm reset and line steering logic of one card interface.
// Assumes status pins are asynchronous and card reception is flagged by the sequencer.
//
// Implementation choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
module ccs_top
	import ccs_pkg::*;
#(
	parameter int unsigned WARM_RST_CYCLES = WARM_CYCLES,
	parameter int unsigned VDD_T1_CYCLES   = T1_CYCLES
)(
	// Clock and reset
	input  wire logic                 ref_clk,
	input  wire logic                 arst_n,
	// Register port
	input  wire logic [3:0]           reg_addr,
	input  wire logic [7:0]           reg_wdata,
	input  wire logic                 reg_wr,
	input  wire logic                 reg_rd,
	output logic      [7:0]           reg_rdata,
	// Status inputs from card and supervisors
	input  wire ccs_evt_t             evt_pins,
	input  wire logic                 seq_rx_en,
	// Host and card signals
	output logic                      irq_n,
	output logic                      card_rst,
	output logic                      session_on,
	output logic                      deact_req,
	// Paired lines, indexed data, aux a, aux b
	input  wire logic [NUM_LINES-1:0] host_side_line_in,
	output ccs_od_t                   host_side_line,
	input  wire logic [NUM_LINES-1:0] card_side_line_in,
	output ccs_od_t                   card_side_line
);
	localparam int WARM_LEN = int'(WARM_RST_CYCLES);

	ccs_evt_t             evt, evt_q;
	logic [NUM_LINES-1:0] host_lv, card_lv, host_lv_q, card_lv_q;
	logic [13:0]          sync_q;

	ccs_sync #(
		.W   (14),
		.RST (SYNC_RST)
	) u_sync (
		.ref_clk (ref_clk),
		.arst_n  (arst_n),
		.d       ({card_side_line_in, host_side_line_in, evt_pins}),
		.q       (sync_q)
	);

	assign evt     = ccs_evt_t'(sync_q[7:0]);
	assign host_lv = sync_q[10:8];
	assign card_lv = sync_q[13:11];

	function automatic logic rose(input logic now, input logic was);
		rose = now & ~was;
	endfunction : rose

	// Register file and interrupt state.
	logic [7:0]  ctrl_q, ctrl_d, sticky_q, sticky_d, en_q, en_d, rdata_d;
	logic [7:0]  set_v;
	logic        irq_n_d, vdd_hold_q, vdd_hold_d, deact_d, kill;
	logic [31:0] vdd_cnt_q, vdd_cnt_d;
	logic        warm_on_q, warm_on_d, rst_d;
	logic [31:0] warm_cnt_q, warm_cnt_d;
	logic        rd_status;

	always_comb
	begin
		set_v            = '0;
		set_v[ST_EARLY]  = rose(evt.early_atr, evt_q.early_atr);
		set_v[ST_MUTE]   = rose(evt.mute, evt_q.mute);
		set_v[ST_CHANGE] = evt.present ^ evt_q.present;
		set_v[ST_OVT]    = rose(evt.over_temp, evt_q.over_temp);
		set_v[ST_OVC]    = rose(evt.over_current, evt_q.over_current);
		set_v[ST_VCC]    = rose(evt.vcc_fault, evt_q.vcc_fault);
		set_v[ST_VDD]    = rose(evt.vdd_fault, evt_q.vdd_fault);
		rd_status        = reg_rd && reg_addr == ADR_STATUS;

		ctrl_d   = ctrl_q;
		en_d     = en_q;
		sticky_d = sticky_q;
		rdata_d  = 8'h00;
		if (reg_wr && reg_addr == ADR_CTRL)
		begin
			ctrl_d = reg_wdata;
		end
		if (reg_wr && reg_addr == ADR_IRQ_EN)
		begin
			en_d = reg_wdata;
		end
		if (reg_wr && reg_addr == ADR_IRQ_CLR)
		begin
			sticky_d = sticky_d & ~reg_wdata;
		end
		if (rd_status)
		begin
			sticky_d = 8'h00;
		end
		// A new event in the clearing cycle must survive, so the set comes last.
		sticky_d = sticky_d | set_v;
		if (reg_rd)
		begin
			unique case (reg_addr)
				ADR_CTRL:   rdata_d = ctrl_q;
				ADR_STATUS: rdata_d = {sticky_q[7:1], evt.present};
				ADR_IRQ_EN: rdata_d = en_q;
				default:    rdata_d = 8'h00;
			endcase
		end

		kill = evt.over_current | evt.over_temp | evt.vcc_fault | evt.vdd_fault
			| (evt_q.present & ~evt.present);
		deact_d = ctrl_q[CTRL_START] & kill;
		if (deact_d)
		begin
			ctrl_d[CTRL_START] = 1'b0;
			ctrl_d[CTRL_WARM]  = 1'b0;
		end
		if (rose(evt.atr_start, evt_q.atr_start) || rose(evt.mute, evt_q.mute))
		begin
			ctrl_d[CTRL_WARM] = 1'b0;
		end

		// The supervisor shares the t1 timer, so a brief glitch still costs a full t1.
		vdd_hold_d = vdd_hold_q;
		vdd_cnt_d  = 32'h0000_0000;
		if (evt.vdd_fault)
		begin
			vdd_hold_d = 1'b1;
		end
		else if (vdd_hold_q)
		begin
			vdd_cnt_d = vdd_cnt_q + 32'h0000_0001;
			if (vdd_cnt_q + 32'h0000_0001 >= VDD_T1_CYCLES)
			begin
				vdd_hold_d = 1'b0;
			end
		end

		irq_n_d = ~(|(sticky_q & en_q) | vdd_hold_q);

		warm_on_d  = warm_on_q;
		warm_cnt_d = warm_cnt_q;
		if (warm_on_q)
		begin
			warm_cnt_d = warm_cnt_q + 32'h0000_0001;
			if (warm_cnt_q + 32'h0000_0001 >= WARM_RST_CYCLES || !ctrl_q[CTRL_START])
			begin
				warm_on_d = 1'b0;
			end
		end
		else if (ctrl_q[CTRL_WARM] && ctrl_q[CTRL_START] && warm_cnt_q == 32'h0)
		begin
			warm_on_d  = 1'b1;
			warm_cnt_d = 32'h0000_0000;
		end
		if (!ctrl_q[CTRL_WARM] && !warm_on_q)
		begin
			warm_cnt_d = 32'h0000_0000;
		end
		rst_d = ctrl_q[CTRL_START] & ~warm_on_d;
	end

	// Only power-on reset resets these registers; a supply fault during a session also clears the start and warm bits.
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ctrl_q     <= CTRL_RST;
			en_q       <= IRQ_EN_RST;
			sticky_q   <= 8'h00;
			evt_q      <= '0;
			reg_rdata  <= 8'h00;
			vdd_hold_q <= 1'b0;
			vdd_cnt_q  <= 32'h0000_0000;
			warm_on_q  <= 1'b0;
			warm_cnt_q <= 32'h0000_0000;
			irq_n      <= 1'b1;
			card_rst   <= 1'b0;
			session_on <= 1'b0;
			deact_req  <= 1'b0;
		end
		else
		begin
			ctrl_q     <= ctrl_d;
			en_q       <= en_d;
			sticky_q   <= sticky_d;
			evt_q      <= evt;
			reg_rdata  <= rdata_d;
			vdd_hold_q <= vdd_hold_d;
			vdd_cnt_q  <= vdd_cnt_d;
			warm_on_q  <= warm_on_d;
			warm_cnt_q <= warm_cnt_d;
			irq_n      <= irq_n_d;
			card_rst   <= rst_d;
			session_on <= ctrl_d[CTRL_START];
			deact_req  <= deact_d;
		end
	end

	// Line direction steering, one state machine per line pair.
	ccs_dir_t dir_q [NUM_LINES];
	ccs_dir_t dir_d [NUM_LINES];
	ccs_od_t  host_d, card_d;

	always_comb
	begin
		for (int i = 0; i < NUM_LINES; i++)
		begin
			dir_d[i] = dir_q[i];
			unique case (dir_q[i])
				DIR_IDLE:
				begin
					if (ctrl_q[CTRL_IO_EN] && seq_rx_en)
					begin
						if (host_lv_q[i] && !host_lv[i])
						begin
							dir_d[i] = DIR_HOST_IN;
						end
						else if (card_lv_q[i] && !card_lv[i])
						begin
							dir_d[i] = DIR_CARD_IN;
						end
					end
				end
				DIR_HOST_IN:
				begin
					if (rose(host_lv[i], host_lv_q[i]) || !ctrl_q[CTRL_IO_EN])
					begin
						dir_d[i] = DIR_IDLE;
					end
				end
				DIR_CARD_IN:
				begin
					if (rose(card_lv[i], card_lv_q[i]) || !ctrl_q[CTRL_IO_EN])
					begin
						dir_d[i] = DIR_IDLE;
					end
				end
				default:
				begin
					dir_d[i] = DIR_IDLE;
				end
			endcase
			host_d.out[i] = 1'b1;
			host_d.oe[i]  = 1'b0;
			card_d.out[i] = 1'b1;
			card_d.oe[i]  = 1'b0;
			if (!seq_rx_en)
			begin
				card_d.out[i] = 1'b0;
				card_d.oe[i]  = 1'b1;
			end
			else if (dir_d[i] == DIR_HOST_IN)
			begin
				card_d.out[i] = host_lv[i];
				card_d.oe[i]  = 1'b1;
			end
			if (dir_d[i] == DIR_CARD_IN)
			begin
				host_d.out[i] = card_lv[i];
				host_d.oe[i]  = 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			for (int i = 0; i < NUM_LINES; i++)
			begin
				dir_q[i] <= DIR_IDLE;
			end
			host_lv_q      <= '1;
			card_lv_q      <= '1;
			host_side_line <= '{out: '1, oe: '0};
			card_side_line <= '{out: '0, oe: '1};
		end
		else
		begin
			for (int i = 0; i < NUM_LINES; i++)
			begin
				dir_q[i] <= dir_d[i];
			end
			host_lv_q      <= host_lv;
			card_lv_q      <= card_lv;
			host_side_line <= host_d;
			card_side_line <= card_d;
		end
	end

	// Checks.
	irq_low_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		|(sticky_q & en_q) |=> !irq_n)
		else $error("interrupt not low with pending enabled source");
	ovt_flag_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		set_v[ST_OVT] |=> sticky_q[ST_OVT] ##1 (!irq_n || !en_q[ST_OVT]))
		else $error("over-temperature flag not set");
	read_clear_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		rd_status && set_v == 8'h00 |=> sticky_q[7:1] == 7'h00)
		else $error("status read did not clear flags");
	vdd_hold_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		evt.vdd_fault |=> vdd_hold_q ##1 !irq_n)
		else $error("supply fault did not hold interrupt");
	vdd_time_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		$fell(vdd_hold_q) |-> vdd_cnt_q + 32'h1 >= VDD_T1_CYCLES)
		else $error("supply hold released early");
	warm_len_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		$fell(warm_on_q) && ctrl_q[CTRL_START] |-> warm_cnt_q == WARM_LEN)
		else $error("warm pulse length wrong");
	warm_pin_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		$rose(warm_on_q) |-> !card_rst ##1 !card_rst)
		else $error("card reset not low during warm pulse");
	warm_clear_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		rose(evt.mute, evt_q.mute) |=> !ctrl_q[CTRL_WARM])
		else $error("warm bit not cleared on mute");
	deact_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		ctrl_q[CTRL_START] && kill |=> !ctrl_q[CTRL_START] && deact_req)
		else $error("fault did not deactivate session");
	card_low_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		!seq_rx_en |=> card_side_line.oe == '1 && card_side_line.out == '0)
		else $error("card lines not low outside reception");
	steer_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		dir_q[LINE_DATA] == DIR_CARD_IN |-> host_side_line.oe[LINE_DATA])
		else $error("host data line not driven while card is input");
endmodule : ccs_top

/* File: verification/ccs_host_model.sv */
// Host controller model: master of the strobe register port.
// Assumes read data stand only in the cycle after the read strobe.
`timescale 1ns/1ps
module ccs_host_model (
	// Clock
	input  wire logic       ref_clk,
	// Register port
	output logic      [3:0] reg_addr,
	output logic      [7:0] reg_wdata,
	output logic            reg_wr,
	output logic            reg_rd,
	input  wire logic [7:0] reg_rdata
);
	initial
	begin
		reg_addr  = 4'h0;
		reg_wdata = 8'h00;
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
	end

	// Warm and start bits are only ever set through this write; faults and extraction clear both while start is set, answer start and mute clear only the warm bit.
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge ref_clk);
		reg_wr    <= 1'b0;
		reg_wdata <= ~d;
	endtask : wr

	// Status interrupts stay low until this read of the status register, or a write to the clear register, is made.
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge ref_clk);
		reg_rd   <= 1'b0;
		#1;
		d = reg_rdata;
	endtask : rd
endmodule : ccs_host_model

/* File: verification/ccs_top_test.sv */
// Self-checking bench for the card control steering block.
// Assumes the host model owns the register port; events and lines are driven here.
`timescale 1ns/1ps
module ccs_top_test
	import ccs_pkg::*;
;
	// Short counts keep the run brief.
	localparam int unsigned WARM_N = 20;
	localparam int unsigned T1_N   = 40;
	logic       ref_clk   = 1'b0;
	logic       arst_n    = 1'b0;
	logic       seq_rx_en = 1'b0;
	ccs_evt_t   ev        = '0;
	logic [2:0] host_in   = 3'h7;
	logic [2:0] card_in   = 3'h7;
	logic [3:0] reg_addr;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata;
	logic [7:0] rv;
	logic       reg_wr;
	logic       reg_rd;
	logic       irq_n;
	logic       card_rst;
	logic       session_on;
	logic       deact_req;
	ccs_od_t    host_ln;
	ccs_od_t    card_ln;
	int         bad_count = 0;
	int         compares  = 0;
	int         cyc       = 0;

	ccs_top #(.WARM_RST_CYCLES(WARM_N), .VDD_T1_CYCLES(T1_N)) ccs_top_i (
		.ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .evt_pins(ev),
		.seq_rx_en(seq_rx_en), .irq_n(irq_n), .card_rst(card_rst), .session_on(session_on),
		.deact_req(deact_req), .host_side_line_in(host_in), .host_side_line(host_ln),
		.card_side_line_in(card_in), .card_side_line(card_ln));

	ccs_host_model ccs_host_model_i (
		.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

	initial
	begin
		forever #2.5 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			bad_count = bad_count + 1;
			summarize();
		end
	end

	task automatic summarize;
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : summarize

	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		compares = compares + 1;
		if (g !== e)
		begin
			bad_count = bad_count + 1;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task automatic tk(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : tk

	task automatic rd_chk(input string n, input logic [3:0] a, input logic [7:0] e);
		ccs_host_model_i.rd(a, rv);
		chk(n, e, rv);
	endtask : rd_chk

	task automatic t_reset;
		chk("irq_n", 8'h01, {7'h0, irq_n});
		chk("host lines", 8'h38, {2'h0, host_ln});
		chk("card lines", 8'h07, {2'h0, card_ln});
		rd_chk("ctrl", ADR_CTRL, 8'h00);
		rd_chk("irq en", ADR_IRQ_EN, 8'hfe);
		rd_chk("unmapped", 4'h2, 8'h00);
		rd_chk("status", ADR_STATUS, 8'h00);
		$display("test reset done");
	endtask : t_reset

	task automatic t_ovt;
		@(posedge ref_clk);
		ev.over_temp <= 1'b1;
		ev.mute      <= 1'b1;
		tk(8);
		chk("irq ovt", 8'h00, {7'h0, irq_n});
		ccs_host_model_i.wr(ADR_IRQ_CLR, 8'h10);
		tk(3);
		chk("irq pend", 8'h00, {7'h0, irq_n});
		rd_chk("status", ADR_STATUS, 8'h04);
		tk(3);
		chk("irq off", 8'h01, {7'h0, irq_n});
		@(posedge ref_clk);
		ev <= '0;
		tk(6);
		ccs_host_model_i.rd(ADR_STATUS, rv);
		$display("test interrupt done");
	endtask : t_ovt

	// Insertion, extraction, early answer and card supply fault all flag through status.
	task automatic t_events;
		@(posedge ref_clk);
		ev.early_atr <= 1'b1;
		ev.vcc_fault <= 1'b1;
		ev.present   <= 1'b1;
		tk(8);
		chk("irq vcc", 8'h00, {7'h0, irq_n});
		rd_chk("status ins", ADR_STATUS, 8'h4b);
		tk(3);
		chk("irq ins off", 8'h01, {7'h0, irq_n});
		@(posedge ref_clk);
		ev <= '0;
		tk(8);
		chk("irq ext", 8'h00, {7'h0, irq_n});
		rd_chk("status ext", ADR_STATUS, 8'h08);
		tk(3);
		chk("irq ext off", 8'h01, {7'h0, irq_n});
		$display("test events done");
	endtask : t_events

	task automatic t_vdd;
		int n;
		n = 0;
		ccs_host_model_i.wr(ADR_CTRL, 8'h80);
		@(posedge ref_clk);
		ev.vdd_fault <= 1'b1;
		tk(8);
		chk("irq vdd", 8'h00, {7'h0, irq_n});
		rd_chk("ctrl kept", ADR_CTRL, 8'h80);
		@(posedge ref_clk);
		ev.vdd_fault <= 1'b0;
		tk(6);
		rd_chk("vdd flag", ADR_STATUS, 8'h80);
		tk(2);
		chk("irq held", 8'h00, {7'h0, irq_n});
		while (irq_n !== 1'b1 && n < 100)
		begin
			n++;
			tk(1);
		end
		chk("hold span", 8'h01, {7'h0, n >= T1_N - 6 && n <= T1_N - 4});
		ccs_host_model_i.wr(ADR_CTRL, 8'h00);
		$display("test supply done");
	endtask : t_vdd

	task automatic t_warm;
		int n;
		for (int k = 0; k < 2; k++)
		begin
			ccs_host_model_i.wr(ADR_CTRL, 8'h01);
			ccs_host_model_i.wr(ADR_CTRL, 8'h03);
			#1;
			n = 0;
			while (card_rst !== 1'b0 && n < 10)
			begin
				n++;
				tk(1);
			end
			n = 0;
			while (card_rst === 1'b0 && n < 100)
			begin
				n++;
				tk(1);
			end
			chk("warm len", WARM_N[7:0], n[7:0]);
			@(posedge ref_clk);
			ev.atr_start <= (k == 0);
			ev.mute      <= (k == 1);
			tk(8);
			rd_chk("warm clr", ADR_CTRL, 8'h01);
			@(posedge ref_clk);
			ev <= '0;
			tk(6);
			ccs_host_model_i.rd(ADR_STATUS, rv);
		end
		@(posedge ref_clk);
		ev.over_current <= 1'b1;
		n = 0;
		while (deact_req !== 1'b1 && n < 12)
		begin
			n++;
			tk(1);
		end
		chk("deact", 8'h01, {7'h0, deact_req});
		tk(2);
		chk("session", 8'h00, {7'h0, session_on});
		rd_chk("ctrl off", ADR_CTRL, 8'h00);
		@(posedge ref_clk);
		ev <= '0;
		tk(6);
		rd_chk("oc flag", ADR_STATUS, 8'h20);
		$display("test warm done");
	endtask : t_warm

	task automatic t_lines;
		ccs_host_model_i.wr(ADR_CTRL, 8'h80);
		@(posedge ref_clk);
		seq_rx_en <= 1'b1;
		tk(8);
		chk("card rx", 8'h07, {5'h0, card_ln.out});
		@(posedge ref_clk);
		host_in[0] <= 1'b0;
		tk(8);
		chk("host in", 8'h02, {5'h0, card_ln.out[0], card_ln.oe[0], host_ln.oe[0]});
		@(posedge ref_clk);
		host_in[0] <= 1'b1;
		tk(8);
		chk("neutral a", 8'h02, {6'h0, card_ln.out[0], host_ln.oe[0]});
		@(posedge ref_clk);
		card_in[1:0] <= 2'b00;
		tk(8);
		chk("card in", 8'h03, {4'h0, host_ln.out[1:0], host_ln.oe[1:0]});
		@(posedge ref_clk);
		card_in[1:0] <= 2'b11;
		tk(8);
		chk("neutral b", 8'h0c, {4'h0, host_ln.out[1:0], host_ln.oe[1:0]});
		$display("test lines done");
	endtask : t_lines

	initial
	begin
		repeat (20) @(posedge ref_clk);
		arst_n <= 1'b1;
		tk(2);
		t_reset();
		t_ovt();
		t_events();
		t_vdd();
		t_warm();
		t_lines();
		summarize();
	end
endmodule : ccs_top_test
